//--- design/dam_pkg.sv
// shared constants and types of the data address index modifier
package dam_pkg;

    // address field widths of the data memory
    localparam int BANK_W    = 4;
    localparam int ROW_W     = 3;
    localparam int COL_W     = 4;
    localparam int ADDR_W    = BANK_W + ROW_W + COL_W;
    localparam int ROWPTR_W  = BANK_W + ROW_W;
    localparam int NIB_W     = 4;

    // avalon slave widths, byte addressed, one register per word
    localparam int AV_ADDR_W = 10;
    localparam int AV_DATA_W = 32;
    localparam int AV_BE_W   = AV_DATA_W / 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_INDEX_BANK = 8'h20;
    localparam logic [7:0] IDX_INDEX_ROW  = 8'h21;
    localparam logic [7:0] IDX_INDEX_COL  = 8'h22;
    localparam logic [7:0] IDX_ROW_PTR    = 8'h23;
    localparam logic [7:0] IDX_INDEX_INC  = 8'h24;
    localparam logic [7:0] IDX_GRP_HIGH   = 8'h7d;
    localparam logic [7:0] IDX_GRP_LOW    = 8'h7e;
    localparam logic [7:0] IDX_STATUS     = 8'h7f;

    // field positions
    localparam int STAT_IDX_EN_BIT = 0;
    localparam int BANK_PTR_EN_BIT = 3;
    localparam int GRP_LOW_BCD_BIT = 0;
    localparam int GRP_LOW_PTR_LSB = 1;

    // reset values, the fixed pointer high nibble read value and the general register bank
    localparam logic [NIB_W-1:0]    RST_NIB      = 4'h0;
    localparam logic [ROW_W-1:0]    RST_ROW      = 3'h0;
    localparam logic [ROWPTR_W-1:0] RST_ROW_PTR  = 7'h00;
    localparam logic [ROW_W-1:0]    RST_GR_PTR   = 3'h0;
    localparam logic [NIB_W-1:0]    GR_HIGH_READ = 4'h0;
    localparam logic [BANK_W-1:0]   GR_BANK      = 4'h0;

    // kind of data memory instruction being addressed
    typedef enum logic [1:0]
    {
        DAM_OP_DIRECT,
        DAM_OP_REG_MEM,
        DAM_OP_INDIRECT
    } dam_op_e;

endpackage

//--- design/dam_addr_merge.sv
`timescale 1ns/1ps
// forms the real direct address and the indirect transfer address
module dam_addr_merge
(
    input  wire logic [dam_pkg::ADDR_W-1:0]   op_addr_in,
    input  wire logic [dam_pkg::ADDR_W-1:0]   index_in,
    input  wire logic [dam_pkg::ROWPTR_W-1:0] row_pointer_in,
    input  wire logic                         index_enable_flag_in,
    input  wire logic                         pointer_enable_flag_in,
    input  wire logic [dam_pkg::COL_W-1:0]    gr_data_in,
    output logic      [dam_pkg::ADDR_W-1:0]   direct_addr_out,
    output logic      [dam_pkg::ADDR_W-1:0]   indirect_addr_out
);
    import dam_pkg::*;

    logic [ROWPTR_W-1:0] base_bank_row;   // bank and row before modification

    // real direct address: or with the index while enabled, any location
    always_comb
    begin
        if (index_enable_flag_in)
        begin
            direct_addr_out = op_addr_in | index_in;
        end
        else
        begin
            direct_addr_out = op_addr_in;
        end
    end

    // indirect address: bank and row from operand or pointer, column from r
    always_comb
    begin
        if (pointer_enable_flag_in)
        begin
            base_bank_row = row_pointer_in;
        end
        else
        begin
            base_bank_row = op_addr_in[ADDR_W-1:COL_W];
        end
        if (index_enable_flag_in)
        begin
            // column stays the register contents, bank and row are or-ed
            indirect_addr_out = {base_bank_row | index_in[ADDR_W-1:COL_W],
                                 gr_data_in};
        end
        else
        begin
            indirect_addr_out = {base_bank_row, gr_data_in};
        end
    end

endmodule

//--- design/dam_gr_locate.sv
`timescale 1ns/1ps
// places a register operand column inside the general register row
module dam_gr_locate
(
    input  wire logic [dam_pkg::ROW_W-1:0]  gr_pointer_in,
    input  wire logic [dam_pkg::COL_W-1:0]  reg_col_in,
    output logic      [dam_pkg::ADDR_W-1:0] reg_addr_out
);
    import dam_pkg::*;

    // bank zero, pointer row, operand column; the index never applies here
    always_comb
    begin
        reg_addr_out = {GR_BANK, gr_pointer_in, reg_col_in};
    end

endmodule

//--- design/dam_index_modifier.sv
`timescale 1ns/1ps
// What this block does
// - enabled index ors into direct operand address
// - register operand of reg-mem stays unmodified
// - indirect bank and row or-ed, column from register
// - status word location is also redirected
// - pointer high nibble reads zero, three bits live
// - reset clears general register pointer
// - index enable flag selects plain or modified
// - pointer enable takes indirect bank/row from pointer
// - general register is one row, column addressed
module dam_index_modifier
(
    input  wire logic                            core_clk_in,
    input  wire logic                            rst_n_in,
    // avalon-mm slave
    input  wire logic [dam_pkg::AV_ADDR_W-1:0]   avs_address_in,
    input  wire logic                            avs_read_in,
    input  wire logic                            avs_write_in,
    input  wire logic [dam_pkg::AV_DATA_W-1:0]   avs_writedata_in,
    input  wire logic [dam_pkg::AV_BE_W-1:0]     avs_byteenable_in,
    output logic      [dam_pkg::AV_DATA_W-1:0]   avs_readdata_out,
    output logic                                 avs_waitrequest_out,
    // instruction execution side
    input  wire logic                            req_valid_in,
    input  wire dam_pkg::dam_op_e                req_op_in,
    input  wire logic [dam_pkg::ADDR_W-1:0]      op_addr_in,
    input  wire logic [dam_pkg::COL_W-1:0]       reg_col_in,
    input  wire logic [dam_pkg::COL_W-1:0]       gr_data_in,
    input  wire logic                            index_inc_in,
    output logic                                 addr_valid_out,
    output logic      [dam_pkg::ADDR_W-1:0]      mem_addr_out,
    output logic      [dam_pkg::ADDR_W-1:0]      reg_addr_out,
    output logic      [dam_pkg::ADDR_W-1:0]      ind_addr_out,
    output logic                                 index_enable_flag_out,
    output logic                                 pointer_enable_flag_out
);
    import dam_pkg::*;

    // whole state of the block
    typedef struct packed
    {
        logic [BANK_W-1:0]    index_bank_part;    // high part, msb ptr enable
        logic [ROW_W-1:0]     index_row_part;     // middle part
        logic [COL_W-1:0]     index_column_part;  // low part
        logic [ROWPTR_W-1:0]  row_pointer;        // bank and row pointer
        logic [NIB_W-1:0]     status_word;        // bit 0 is index enable
        logic [ROW_W-1:0]     gr_pointer;         // live pointer bits
        logic                 bcd_flag;           // shares the low nibble
        logic                 ack;                // bus answer cycle
        logic [AV_DATA_W-1:0] rdata;              // registered read data
        logic                 out_valid;          // address result strobe
        logic [ADDR_W-1:0]    mem_addr;           // real memory address
        logic [ADDR_W-1:0]    reg_addr;           // general register address
        logic [ADDR_W-1:0]    ind_addr;           // indirect or direct address
    } dam_state_s;

    dam_state_s          state_reg;     // registered state
    dam_state_s          state_next;    // next state
    logic [7:0]          reg_idx;       // word index of the bus access
    logic                bus_req;       // bus access pending
    logic                wr_take;       // write takes effect this edge
    logic                rd_take;       // read answered this edge
    logic [ADDR_W-1:0]   index_value;   // concatenated index register
    logic [ADDR_W-1:0]   index_incr;    // index plus one
    logic                idx_en;        // index enable flag
    logic                ptr_en;        // pointer enable flag
    logic [ADDR_W-1:0]   direct_addr;   // merged direct address
    logic [ADDR_W-1:0]   indirect_addr; // merged indirect address
    logic [ADDR_W-1:0]   gr_addr;       // register operand address
    logic [AV_DATA_W-1:0] rd_mux;       // read data selection
    logic [NIB_W-1:0]    wr_nib;        // low nibble of write data

    // bus decode; waitrequest drops in the answer cycle only
    assign reg_idx   = avs_address_in[AV_ADDR_W-1:2];
    assign bus_req   = avs_read_in | avs_write_in;
    assign wr_take   = avs_write_in & state_reg.ack & avs_byteenable_in[0];
    assign rd_take   = avs_read_in & ~state_reg.ack;
    assign wr_nib    = avs_writedata_in[NIB_W-1:0];
    assign avs_waitrequest_out = bus_req & ~state_reg.ack;

    // index is one value made of its three aligned parts
    assign index_value = {state_reg.index_bank_part,
                          state_reg.index_row_part,
                          state_reg.index_column_part};
    assign index_incr  = index_value + 11'h001;
    assign idx_en = state_reg.status_word[STAT_IDX_EN_BIT];
    assign ptr_en = state_reg.index_bank_part[BANK_PTR_EN_BIT];

    // address merging with index and memory pointer
    dam_addr_merge u_merge
    (
        .op_addr_in             (op_addr_in),
        .index_in               (index_value),
        .row_pointer_in         (state_reg.row_pointer),
        .index_enable_flag_in   (idx_en),
        .pointer_enable_flag_in (ptr_en),
        .gr_data_in             (gr_data_in),
        .direct_addr_out        (direct_addr),
        .indirect_addr_out      (indirect_addr)
    );

    // general register location from the pointer
    dam_gr_locate u_gr
    (
        .gr_pointer_in (state_reg.gr_pointer),
        .reg_col_in    (reg_col_in),
        .reg_addr_out  (gr_addr)
    );

    // register read data; high pointer nibble always reads zero
    always_comb
    begin
        rd_mux = '0;
        case (reg_idx)
            IDX_INDEX_BANK: rd_mux[NIB_W-1:0] = state_reg.index_bank_part;
            IDX_INDEX_ROW:  rd_mux[ROW_W-1:0] = state_reg.index_row_part;
            IDX_INDEX_COL:  rd_mux[COL_W-1:0] = state_reg.index_column_part;
            IDX_ROW_PTR:    rd_mux[ROWPTR_W-1:0] = state_reg.row_pointer;
            IDX_GRP_HIGH:   rd_mux[NIB_W-1:0] = GR_HIGH_READ;
            IDX_GRP_LOW:    rd_mux[NIB_W-1:0] = {state_reg.gr_pointer,
                                                 state_reg.bcd_flag};
            IDX_STATUS:     rd_mux[NIB_W-1:0] = state_reg.status_word;
            default:        rd_mux = '0;        // unmapped reads zero
        endcase
    end

    // next state: bus, index increment and address results
    always_comb
    begin
        state_next       = state_reg;
        state_next.ack   = bus_req & ~state_reg.ack;
        if (rd_take)
        begin
            state_next.rdata = rd_mux;          // stands in the answer cycle
        end
        // increment first, so a same-cycle bus write wins
        if (index_inc_in)
        begin
            state_next.index_bank_part   =
                index_incr[ADDR_W-1:ROW_W+COL_W];
            state_next.index_row_part    =
                index_incr[ROW_W+COL_W-1:COL_W];
            state_next.index_column_part = index_incr[COL_W-1:0];
        end
        if (wr_take)
        begin
            case (reg_idx)
                IDX_INDEX_BANK: state_next.index_bank_part = wr_nib;
                IDX_INDEX_ROW:
                    state_next.index_row_part = wr_nib[ROW_W-1:0];
                IDX_INDEX_COL:  state_next.index_column_part = wr_nib;
                IDX_ROW_PTR:
                    state_next.row_pointer =
                        avs_writedata_in[ROWPTR_W-1:0];
                IDX_INDEX_INC:
                begin
                    // a software increment of the whole index
                    state_next.index_bank_part   =
                        index_incr[ADDR_W-1:ROW_W+COL_W];
                    state_next.index_row_part    =
                        index_incr[ROW_W+COL_W-1:COL_W];
                    state_next.index_column_part = index_incr[COL_W-1:0];
                end
                IDX_GRP_LOW:
                begin
                    state_next.gr_pointer =
                        wr_nib[NIB_W-1:GRP_LOW_PTR_LSB];
                    state_next.bcd_flag = wr_nib[GRP_LOW_BCD_BIT];
                end
                IDX_STATUS:     state_next.status_word = wr_nib;
                default:        state_next.rdata = state_reg.rdata;
            endcase
        end
        // address result for the instruction being executed
        state_next.out_valid = req_valid_in;
        if (req_valid_in)
        begin
            state_next.mem_addr = direct_addr;
            state_next.reg_addr = gr_addr;
            case (req_op_in)
                DAM_OP_INDIRECT: state_next.ind_addr = indirect_addr;
                DAM_OP_REG_MEM:  state_next.ind_addr = direct_addr;
                DAM_OP_DIRECT:   state_next.ind_addr = direct_addr;
                default:         state_next.ind_addr = direct_addr;
            endcase
        end
    end

    // state register; reset clears pointer, index and flags
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_reg                   <= '0;
            state_reg.index_bank_part   <= RST_NIB;
            state_reg.index_row_part    <= RST_ROW;
            state_reg.index_column_part <= RST_NIB;
            state_reg.row_pointer       <= RST_ROW_PTR;
            state_reg.status_word       <= RST_NIB;
            state_reg.gr_pointer        <= RST_GR_PTR;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state
    assign avs_readdata_out        = state_reg.rdata;
    assign addr_valid_out          = state_reg.out_valid;
    assign mem_addr_out            = state_reg.mem_addr;
    assign reg_addr_out            = state_reg.reg_addr;
    assign ind_addr_out            = state_reg.ind_addr;
    assign index_enable_flag_out   = idx_en;
    assign pointer_enable_flag_out = ptr_en;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // modified direct address is the or of operand and index
    direct_or_a: assert property (
        req_valid_in && idx_en |=>
            mem_addr_out == $past(op_addr_in | index_value))
        else $error("direct address not or-ed with index");

    // disabled index leaves the operand untouched, status word included
    direct_plain_a: assert property (
        req_valid_in && !idx_en |=> addr_valid_out &&
            mem_addr_out == $past(op_addr_in))
        else $error("direct address changed while index disabled");

    // register operand never modified by the index
    reg_unmod_a: assert property (
        req_valid_in |=> reg_addr_out ==
            {GR_BANK, $past(state_reg.gr_pointer), $past(reg_col_in)})
        else $error("register operand address modified");

    // indirect column comes from register contents
    ind_col_a: assert property (
        req_valid_in && req_op_in == DAM_OP_INDIRECT |=>
            ind_addr_out[COL_W-1:0] == $past(gr_data_in))
        else $error("indirect column not from register data");

    // pointer enable supplies indirect bank and row
    ind_pointer_a: assert property (
        req_valid_in && req_op_in == DAM_OP_INDIRECT && ptr_en && !idx_en |=>
            ind_addr_out[ADDR_W-1:COL_W] == $past(state_reg.row_pointer))
        else $error("indirect bank and row not from pointer");

    // pointer high nibble reads zero
    grp_high_a: assert property (
        avs_read_in && reg_idx == IDX_GRP_HIGH && !state_reg.ack |=>
            avs_readdata_out == '0 && !avs_waitrequest_out)
        else $error("pointer high nibble read nonzero");

    // pointer is zero right after reset
    reset_ptr_a: assert property (
        $rose(rst_n_in) |-> state_reg.gr_pointer == RST_GR_PTR)
        else $error("general register pointer not cleared");

    // increment carries through all three parts
    inc_carry_a: assert property (
        index_inc_in && !wr_take |=>
            index_value == ($past(index_value) + 11'h001))
        else $error("index increment lost a carry");

    // every bus access is answered within one cycle
    bus_answer_a: assert property (
        bus_req |-> ##[0:1] !avs_waitrequest_out)
        else $error("bus access not answered");

    // answer pulse follows each request by exactly one cycle
    valid_pulse_a: assert property (
        1'b1 |=> addr_valid_out == $past(req_valid_in))
        else $error("address answer pulse misplaced");

    // non-indirect kinds report the real direct address twice
    ind_same_a: assert property (
        req_valid_in && req_op_in != DAM_OP_INDIRECT |=>
            ind_addr_out == mem_addr_out)
        else $error("second address differs from direct address");

    // enabled index ors into the indirect bank and row as well
    ind_index_a: assert property (
        req_valid_in && req_op_in == DAM_OP_INDIRECT && idx_en && !ptr_en
            |=> ind_addr_out[ADDR_W-1:COL_W] ==
            $past(op_addr_in[ADDR_W-1:COL_W] | index_value[ADDR_W-1:COL_W]))
        else $error("indirect bank and row not index modified");

    // reset clears the pointer whatever the bus does meanwhile
    reset_clear_a: assert property (
        disable iff (1'b0)
        !rst_n_in |=> state_reg.gr_pointer == RST_GR_PTR)
        else $error("pointer not cleared during reset");

    // pointer write lands in the three live bits
    grp_write_a: assert property (
        wr_take && reg_idx == IDX_GRP_LOW |=>
            state_reg.gr_pointer == $past(wr_nib[NIB_W-1:GRP_LOW_PTR_LSB]))
        else $error("pointer write not stored");

    // status write sets or clears the index enable level
    enable_write_a: assert property (
        wr_take && reg_idx == IDX_STATUS |=>
            index_enable_flag_out == $past(wr_nib[STAT_IDX_EN_BIT]))
        else $error("index enable not taken from status write");

    // a bus increment steps the whole index by one
    bus_inc_a: assert property (
        wr_take && reg_idx == IDX_INDEX_INC && !index_inc_in |=>
            index_value == ($past(index_value) + 11'h001))
        else $error("bus increment of the index wrong");

endmodule

//--- bench/dam_index_modifier_tb_top.sv
`timescale 1ns/1ps
// self-checking bench of the data address index modifier
module dam_index_modifier_tb_top;
    import dam_pkg::*;

    logic                 core_clk;    // 200 MHz core clock
    logic                 rst_n;       // synchronous reset, active low
    logic [AV_ADDR_W-1:0] av_addr;     // bus byte address
    logic                 av_rd;       // bus read request
    logic                 av_wr;       // bus write request
    logic [AV_DATA_W-1:0] av_wdata;    // bus write data
    logic [AV_BE_W-1:0]   av_be;       // bus byte enables
    logic [AV_DATA_W-1:0] av_rdata;    // bus read data
    logic                 av_wait;     // bus wait request
    logic                 rq_valid;    // address request pulse
    dam_op_e              rq_op;       // kind of instruction
    logic [ADDR_W-1:0]    rq_addr;     // direct operand
    logic [COL_W-1:0]     rq_col;      // register operand column
    logic [COL_W-1:0]     rq_gr;       // register contents
    logic                 inc;         // index increment pulse
    logic                 a_valid;     // answer pulse
    logic [ADDR_W-1:0]    a_mem;       // real direct address
    logic [ADDR_W-1:0]    a_reg;       // register operand address
    logic [ADDR_W-1:0]    a_ind;       // indirect address
    logic                 ien_flag;    // index enable level
    logic                 pen_flag;    // pointer enable level
    int                   failures;        // mismatches seen
    int                   samples_checked; // comparisons made
    logic [ADDR_W-1:0]    m_idx;       // expected index value
    logic [ROWPTR_W-1:0]  m_rowp;      // expected row pointer
    logic                 m_ien;       // expected enable flag
    logic [ROW_W-1:0]     m_grp;       // expected register row
    logic [AV_DATA_W-1:0] rd;          // last read result

    dam_index_modifier dut
    (
        .core_clk_in(core_clk), .rst_n_in(rst_n),
        .avs_address_in(av_addr), .avs_read_in(av_rd),
        .avs_write_in(av_wr), .avs_writedata_in(av_wdata),
        .avs_byteenable_in(av_be), .avs_readdata_out(av_rdata),
        .avs_waitrequest_out(av_wait), .req_valid_in(rq_valid),
        .req_op_in(rq_op), .op_addr_in(rq_addr), .reg_col_in(rq_col),
        .gr_data_in(rq_gr), .index_inc_in(inc),
        .addr_valid_out(a_valid), .mem_addr_out(a_mem),
        .reg_addr_out(a_reg), .ind_addr_out(a_ind),
        .index_enable_flag_out(ien_flag),
        .pointer_enable_flag_out(pen_flag)
    );

    // free running clock, 5 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // prints the counts and the verdict, then stops
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one comparison; x or z never matches
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one bus transfer, held until wait request is sampled low
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, input logic [3:0] be,
                       output logic [31:0] rdv);
        int n;
        n = 0;
        @(posedge core_clk);
        av_addr  <= {idx, 2'b00};
        av_rd    <= ~wr;
        av_wr    <= wr;
        av_wdata <= wd;
        av_be    <= be;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (av_wait !== 1'b0 && n < 50);
        rdv = av_rdata;
        if (n >= 50)
            chk(1'b0, 1'b1, "bus answer missing");
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask

    // loads all three index parts and mirrors them
    task automatic set_idx(input logic [ADDR_W-1:0] v);
        bus(1'b1, IDX_INDEX_BANK, {28'h0, v[10:7]}, 4'h1, rd);
        bus(1'b1, IDX_INDEX_ROW, {29'h0, v[6:4]}, 4'h1, rd);
        bus(1'b1, IDX_INDEX_COL, {28'h0, v[3:0]}, 4'h1, rd);
        m_idx = v;
    endtask

    // real direct address the bench expects
    function automatic logic [ADDR_W-1:0] f_mem(input logic [10:0] op);
        return m_ien ? (op | m_idx) : op;
    endfunction

    // indirect address the bench expects
    function automatic logic [ADDR_W-1:0] f_ind(input dam_op_e k,
        input logic [10:0] op, input logic [3:0] g);
        logic [ROWPTR_W-1:0] br;
        if (k != DAM_OP_INDIRECT)
            return f_mem(op);
        br = m_idx[10] ? m_rowp : op[10:4];
        if (m_ien)
            br = br | m_idx[10:4];
        return {br, g};
    endfunction

    // one address request and the check of its answer
    task automatic req(input dam_op_e k, input logic [10:0] op,
                       input logic [3:0] c, input logic [3:0] g);
        @(posedge core_clk);
        rq_valid <= 1'b1;
        rq_op    <= k;
        rq_addr  <= op;
        rq_col   <= c;
        rq_gr    <= g;
        @(posedge core_clk);
        rq_valid <= 1'b0;
        #1;
        chk(a_valid, 1'b1, "answer pulse");
        chk(a_mem, f_mem(op), "direct address");
        chk(a_reg, {GR_BANK, m_grp, c}, "register address");
        chk(a_ind, f_ind(k, op, g), "indirect address");
        chk(ien_flag, m_ien, "enable flag");
        chk(pen_flag, m_idx[10], "pointer flag");
    endtask

    // cuts a hang short
    initial
    begin
        repeat (40000) @(posedge core_clk);
        failures++;
        finish_test();
    end

    // main sequence
    initial
    begin
        logic [7:0] regs [8];
        failures = 0; samples_checked = 0;
        rst_n = 1'b0; av_addr = '0; av_rd = 1'b0; av_wr = 1'b0;
        av_wdata = '0; av_be = '0; rq_valid = 1'b0; rq_op = DAM_OP_DIRECT;
        rq_addr = '0; rq_col = '0; rq_gr = '0; inc = 1'b0;
        m_idx = '0; m_rowp = '0; m_ien = 1'b0; m_grp = '0;
        regs = '{IDX_INDEX_BANK, IDX_INDEX_ROW, IDX_INDEX_COL, IDX_ROW_PTR,
                 IDX_GRP_HIGH, IDX_GRP_LOW, IDX_STATUS, 8'h10};
        void'($urandom(99));
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        // every register reads zero after reset; 0x10 is unmapped
        foreach (regs[i])
        begin
            bus(1'b0, regs[i], '0, 4'h1, rd);
            chk(rd, 32'h0, "reset value");
        end
        req(DAM_OP_REG_MEM, 11'h061, 4'h3, 4'h0);
        $display("test reset done");
        // upper pointer nibble is read only, lower one stores
        bus(1'b1, IDX_GRP_HIGH, 32'h0000_000f, 4'h1, rd);
        bus(1'b0, IDX_GRP_HIGH, '0, 4'h1, rd);
        chk(rd, {28'h0, GR_HIGH_READ}, "pointer high");
        bus(1'b1, IDX_GRP_LOW, 32'h0000_000b, 4'h1, rd);
        bus(1'b0, IDX_GRP_LOW, '0, 4'h1, rd);
        chk(rd, 32'h0000_000b, "pointer low");
        m_grp = 3'h5;
        bus(1'b1, IDX_INDEX_COL, 32'h0000_0007, 4'h0, rd);
        bus(1'b0, IDX_INDEX_COL, '0, 4'h1, rd);
        chk(rd, 32'h0, "disabled byte lane");
        req(DAM_OP_DIRECT, 11'h061, 4'h9, 4'h0);
        // reset in mid-run brings the register row back to zero
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        m_grp = '0;
        bus(1'b0, IDX_GRP_LOW, '0, 4'h1, rd);
        chk(rd, 32'h0, "pointer after reset");
        $display("test pointer done");
        // worked cases: modified add, indirect move, status location
        set_idx(11'h012);
        bus(1'b1, IDX_STATUS, 32'h0000_0001, 4'h1, rd);
        m_ien = 1'b1;
        req(DAM_OP_REG_MEM, 11'h061, 4'h3, 4'h0);
        set_idx(11'h001);
        req(DAM_OP_INDIRECT, 11'h034, 4'h5, 4'h8);
        set_idx(11'h100);
        req(DAM_OP_DIRECT, 11'h07f, 4'h0, 4'h0);
        $display("test worked cases done");
        // increment carries across column, row and bank parts
        set_idx(11'h07f);
        @(posedge core_clk);
        inc <= 1'b1;
        @(posedge core_clk);
        inc <= 1'b0;
        m_idx = 11'h080;
        bus(1'b0, IDX_INDEX_BANK, '0, 4'h1, rd);
        chk(rd, 32'h1, "bank part after carry");
        bus(1'b0, IDX_INDEX_ROW, '0, 4'h1, rd);
        chk(rd, 32'h0, "row part after carry");
        bus(1'b0, IDX_INDEX_COL, '0, 4'h1, rd);
        chk(rd, 32'h0, "column part after carry");
        // software increment through the bus register
        bus(1'b1, IDX_INDEX_INC, '0, 4'h1, rd);
        m_idx = 11'h081;
        req(DAM_OP_DIRECT, 11'h000, 4'h0, 4'h0);
        $display("test increment done");
        // random index, pointer, flags and operands
        repeat (30)
        begin
            set_idx(11'($urandom));
            m_rowp = 7'($urandom);
            bus(1'b1, IDX_ROW_PTR, {25'h0, m_rowp}, 4'h1, rd);
            m_ien = 1'($urandom);
            bus(1'b1, IDX_STATUS, {31'h0, m_ien}, 4'h1, rd);
            m_grp = 3'($urandom);
            bus(1'b1, IDX_GRP_LOW, {28'h0, m_grp, 1'b0}, 4'h1, rd);
            repeat (4)
                req(dam_op_e'($urandom_range(2)), 11'($urandom),
                    4'($urandom), 4'($urandom));
        end
        $display("test random done");
        finish_test();
    end
endmodule
